// *** design/drc_map.svh ***
// Register map, field positions and reset values of the DMA request controller.
// How it works
// - Simultaneous requests are served audio, touch, serial rx, serial tx, keyboard.
// - Sequencer enable and transfer enable bits together allow or block DMA activity.
// - Reset bit 0 reinitialises the controller while 1; read/write, resets to 0.
// - Unused register bits read back as 0; software writes them as 0.
// - Idle bit 0 reads 1 while the sequencer idles, 0 in use, 0 after reset.
// - Sequencer enable bit 0 enables the sequencer when 1; resets to 0.
// - Transfer enable bits 4..0 enable keyboard, audio, tx, rx, touch; reset 0.
// - Request register shows pending requests, same bit mapping, read only.
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

// Register addresses as seen on the register port.
`define DRC_ADDR_RESET    32'h0b000040
`define DRC_ADDR_IDLE     32'h0b000042
`define DRC_ADDR_SEQ_EN   32'h0b000044
`define DRC_ADDR_XFER_EN  32'h0b000046
`define DRC_ADDR_REQ      32'h0b000048

// Field positions and widths.
`define DRC_BIT_RESET     0
`define DRC_BIT_IDLE      0
`define DRC_BIT_SEQ_EN    0
`define DRC_SRC_W         5
`define DRC_SRC_TOUCH     0
`define DRC_SRC_SER_RX    1
`define DRC_SRC_SER_TX    2
`define DRC_SRC_AUDIO     3
`define DRC_SRC_KEYBOARD  4

// Reset values.
`define DRC_RST_BIT       1'h0
`define DRC_RST_SRC       5'h00
`define DRC_RST_DATA      16'h0000

`endif

// *** design/drc_pkg.sv ***
// Types shared by the DMA request controller modules.
package drc_pkg;

    // One bit per DMA source, laid out as in the enable and request registers.
    typedef struct packed {
        logic keyboard;
        logic audio;
        logic serial_tx;
        logic serial_rx;
        logic touch_panel;
    } drc_src_s;

    // Register port request from the processor side.
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } drc_bus_s;

    // Register data word.
    typedef logic [15:0] drc_data_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUS_REQ,
        ST_XFER,
        ST_RELEASE
    } drc_state_e;

endpackage

// *** design/drc_prio.sv ***
// Fixed priority selector for the DMA sources.
`timescale 1ns/100ps
`include "drc_map.svh"
module drc_prio (
    input  wire drc_pkg::drc_src_s req,
    output drc_pkg::drc_src_s      grant,
    output logic                   any
);
    import drc_pkg::*;

    // Returns a one-hot pick of the highest priority source in a request word.
    function automatic logic [4:0] pick(input logic [4:0] r);
        logic [4:0] g;
        g = 5'h00;
        if (r[`DRC_SRC_AUDIO]) begin
            g[`DRC_SRC_AUDIO] = 1'b1;
        end else if (r[`DRC_SRC_TOUCH]) begin
            g[`DRC_SRC_TOUCH] = 1'b1;
        end else if (r[`DRC_SRC_SER_RX]) begin
            g[`DRC_SRC_SER_RX] = 1'b1;
        end else if (r[`DRC_SRC_SER_TX]) begin
            g[`DRC_SRC_SER_TX] = 1'b1;
        end else if (r[`DRC_SRC_KEYBOARD]) begin
            g[`DRC_SRC_KEYBOARD] = 1'b1;
        end
        return g;
    endfunction

    assign grant = drc_src_s'(pick(req));
    assign any   = |req;
endmodule

// *** design/drc_rdmux.sv ***
// Read data selection for the DMA request controller registers.
`timescale 1ns/100ps
`include "drc_map.svh"
module drc_rdmux (
    input  wire logic [31:0]       addr,
    input  wire logic              reset_bit,
    input  wire logic              idle_flag,
    input  wire logic              seq_en,
    input  wire drc_pkg::drc_src_s xfer_en,
    input  wire drc_pkg::drc_src_s req,
    output drc_pkg::drc_data_t     data
);
    import drc_pkg::*;

    always_comb begin
        data = `DRC_RST_DATA;
        if (addr == `DRC_ADDR_RESET) begin
            data[`DRC_BIT_RESET] = reset_bit;
        end else if (addr == `DRC_ADDR_IDLE) begin
            data[`DRC_BIT_IDLE] = idle_flag;
        end else if (addr == `DRC_ADDR_SEQ_EN) begin
            data[`DRC_BIT_SEQ_EN] = seq_en;
        end else if (addr == `DRC_ADDR_XFER_EN) begin
            data[`DRC_SRC_W-1:0] = xfer_en;
        end else if (addr == `DRC_ADDR_REQ) begin
            data[`DRC_SRC_W-1:0] = req;
        end
    end
endmodule

// *** design/drc_top.sv ***
// DMA request controller: register port, fixed priority and bus sequencer.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "drc_map.svh"
module drc_top (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire drc_pkg::drc_bus_s reg_bus,
    output drc_pkg::drc_data_t     rdata,
    input  wire drc_pkg::drc_src_s dma_req,
    output drc_pkg::drc_src_s      dma_ack,
    output logic                   bus_req,
    input  wire logic              bus_ack
);
    import drc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic       reset_bit_q;
    logic       reset_bit_d;
    logic       seq_en_q;
    logic       seq_en_d;
    drc_src_s   xfer_en_q;
    drc_src_s   xfer_en_d;
    logic       idle_q;
    logic       idle_d;
    drc_data_t  rdata_q;
    drc_data_t  rdata_d;
    drc_data_t  rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    drc_state_e state_q;
    drc_state_e state_d;
    logic       bus_req_q;
    logic       bus_req_d;
    drc_src_s   grant_q;
    drc_src_s   grant_d;
    drc_src_s   active;
    drc_src_s   winner;
    logic       any_active;
    logic       granted_live;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.

    // Software writes take effect in the cycle after the strobe; unused bits are dropped.
    always_comb begin
        reset_bit_d = reset_bit_q;
        seq_en_d    = seq_en_q;
        xfer_en_d   = xfer_en_q;
        if (reg_bus.wr) begin
            if (reg_bus.addr == `DRC_ADDR_RESET) begin
                reset_bit_d = reg_bus.wdata[`DRC_BIT_RESET];
            end else if (reg_bus.addr == `DRC_ADDR_SEQ_EN) begin
                seq_en_d = reg_bus.wdata[`DRC_BIT_SEQ_EN];
            end else if (reg_bus.addr == `DRC_ADDR_XFER_EN) begin
                xfer_en_d = drc_src_s'(reg_bus.wdata[`DRC_SRC_W-1:0]);
            end
        end
    end

    // Registers the software visible control bits.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reset_bit_q <= `DRC_RST_BIT;
            seq_en_q    <= `DRC_RST_BIT;
            xfer_en_q   <= `DRC_RST_SRC;
        end else begin
            reset_bit_q <= reset_bit_d;
            seq_en_q    <= seq_en_d;
            xfer_en_q   <= xfer_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads.

    // Selects the addressed word; unmapped addresses read as zero.
    drc_rdmux u_rdmux (
        .addr      (reg_bus.addr),
        .reset_bit (reset_bit_q),
        .idle_flag (idle_q),
        .seq_en    (seq_en_q),
        .xfer_en   (xfer_en_q),
        .req       (dma_req),
        .data      (rd_word)
    );

    // Read data stand only in the cycle after the read strobe.
    always_comb begin
        rdata_d = `DRC_RST_DATA;
        if (reg_bus.rd) begin
            rdata_d = rd_word;
        end
    end

    // The idle flag follows the sequencer one cycle late and is 0 out of reset.
    always_comb begin
        idle_d = (state_q == ST_IDLE);
    end

    // Registers the read side.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `DRC_RST_DATA;
            idle_q  <= `DRC_RST_BIT;
        end else begin
            rdata_q <= rdata_d;
            idle_q  <= idle_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request selection.

    // Only enabled sources compete; the winner is taken at the acknowledge.
    assign active = dma_req & xfer_en_q;

    drc_prio u_prio (
        .req   (active),
        .grant (winner),
        .any   (any_active)
    );

    // The served source still asks for its transfer.
    assign granted_live = |(dma_req & grant_q);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // Asks for the bus, serves one source per tenure and releases the bus.
    always_comb begin
        state_d   = state_q;
        bus_req_d = bus_req_q;
        grant_d   = grant_q;
        case (state_q)
            ST_IDLE: begin
                if (seq_en_q && any_active) begin
                    state_d   = ST_BUS_REQ;
                    bus_req_d = 1'b1;
                end
            end
            ST_BUS_REQ: begin
                if (!seq_en_q || !any_active) begin
                    state_d   = ST_RELEASE;
                    bus_req_d = 1'b0;
                end else if (bus_ack) begin
                    state_d = ST_XFER;
                    grant_d = winner;
                end
            end
            ST_XFER: begin
                if (!bus_ack || !granted_live || !seq_en_q) begin
                    state_d   = ST_RELEASE;
                    bus_req_d = 1'b0;
                    grant_d   = `DRC_RST_SRC;
                end
            end
            ST_RELEASE: begin
                bus_req_d = 1'b0;
                grant_d   = `DRC_RST_SRC;
                if (!bus_ack) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d   = ST_IDLE;
                bus_req_d = 1'b0;
                grant_d   = `DRC_RST_SRC;
            end
        endcase
        if (reset_bit_q) begin
            state_d   = ST_IDLE;
            bus_req_d = 1'b0;
            grant_d   = `DRC_RST_SRC;
        end
    end

    // Registers the sequencer.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            bus_req_q <= 1'b0;
            grant_q   <= `DRC_RST_SRC;
        end else begin
            state_q   <= state_d;
            bus_req_q <= bus_req_d;
            grant_q   <= grant_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign rdata   = rdata_q;
    assign dma_ack = grant_q;
    assign bus_req = bus_req_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_prio_audio_first: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == ST_BUS_REQ && bus_ack && seq_en_q && !reset_bit_q && active.audio)
        |=> (grant_q == drc_src_s'(5'h08)))
        else $error("audio request was not served first");

    // touch beats the serial and keyboard sources
    chk_prio_touch_next: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == ST_BUS_REQ && bus_ack && seq_en_q && !reset_bit_q
         && !active.audio && active.touch_panel)
        |=> (grant_q == drc_src_s'(5'h01)))
        else $error("touch panel request lost its priority");

    chk_grant_with_bus: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(|grant_q) |-> ($past(bus_ack) && bus_req_q && $onehot(grant_q)))
        else $error("grant issued without bus acknowledge");

    // reset bit reads back what was written
    chk_reset_bit_rw: assert property (
        @(posedge clock) disable iff (!rst_n)
        (reg_bus.wr && reg_bus.addr == `DRC_ADDR_RESET) ##1 (reg_bus.rd
         && reg_bus.addr == `DRC_ADDR_RESET && !reg_bus.wr)
        |=> (rdata_q == {15'h0000, $past(reset_bit_q)}))
        else $error("reset bit read back wrong");

    chk_unused_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        rdata_q[15:`DRC_SRC_W] == 11'h000)
        else $error("unused read bits not zero");

    chk_idle_flag: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q != ST_IDLE) |=> !idle_q)
        else $error("idle flag does not follow the sequencer");

    chk_idle_set: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == ST_IDLE) |=> idle_q)
        else $error("idle flag stayed low while the sequencer idled");

    chk_seq_disabled: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == ST_IDLE && !seq_en_q) |=> (state_q == ST_IDLE && !bus_req_q))
        else $error("sequencer left idle while disabled");

    chk_mask_blocks: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == ST_BUS_REQ && active == drc_src_s'(5'h00)) |=> (grant_q == 5'h00))
        else $error("disabled source was granted");

    // request register mirrors the request lines
    chk_req_status: assert property (
        @(posedge clock) disable iff (!rst_n)
        (reg_bus.rd && reg_bus.addr == `DRC_ADDR_REQ)
        |=> (rdata_q == {11'h000, $past(dma_req)}))
        else $error("request status does not match the request lines");

    // demand leads to a bus request
    chk_bus_request: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == ST_IDLE && seq_en_q && any_active && !reset_bit_q)
        |=> (bus_req_q && state_q == ST_BUS_REQ))
        else $error("enabled request did not ask for the bus");

    // controller reset clears the sequencer state, bus request and grant next cycle
    chk_reset_abandon: assert property (
        @(posedge clock) disable iff (!rst_n)
        reset_bit_q |=> (state_q == ST_IDLE && !bus_req_q && grant_q == 5'h00))
        else $error("controller reset left a transfer running");

endmodule

// *** tb/drc_far.sv ***
// Behavioural peripherals and bus arbiter on the far side of the DMA request controller.
`timescale 1ns/100ps
module drc_far (
    input  wire drc_pkg::drc_src_s want,
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              hold,
    input  wire logic              slow,
    input  wire drc_pkg::drc_src_s dma_ack,
    input  wire logic              bus_req,
    output drc_pkg::drc_src_s      dma_req,
    output logic                   bus_ack
);
    import drc_pkg::*;
    drc_src_s   done_q;
    logic [1:0] wait_q;
    ////////////////////////////////////////////////////////////
    // peripheral request lines
    // A peripheral asks until it has been served once; hold keeps it asking.
    assign dma_req = drc_src_s'(want & ~done_q);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= '0;
        end else begin
            done_q <= drc_src_s'((done_q | (dma_ack & {5{!hold}})) & want);
        end
    end
    // arbiter acknowledge timing
    // The arbiter answers one cycle after the request, or four cycles after it when slow, and withdraws when released.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 2'h0;
            bus_ack <= 1'b0;
        end else if (!bus_req) begin
            wait_q <= 2'h0;
            bus_ack <= 1'b0;
        end else if (slow && wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            bus_ack <= 1'b1;
        end
    end
endmodule

// *** tb/test_drc_top.sv ***
// Self-checking bench for the DMA request controller.
`timescale 1ns/100ps
`include "drc_map.svh"
module test_drc_top;
    import drc_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    drc_bus_s    bus = '0;
    drc_data_t   rdata;
    drc_src_s    dma_req, dma_ack, want = '0, last = '0;
    drc_src_s    seen[$];
    logic        bus_req, bus_ack, hold = 1'b0, slow = 1'b0;
    int          failures = 0, num_checks = 0, i, n;
    logic [31:0] addrs[6] = '{`DRC_ADDR_RESET, `DRC_ADDR_IDLE, `DRC_ADDR_SEQ_EN,
                              `DRC_ADDR_XFER_EN, `DRC_ADDR_REQ, 32'h0b00004a};
    drc_data_t   exp_rst[6] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    drc_data_t   exp_set[6] = '{16'h0001, 16'h0001, 16'h0001, 16'h001f, 16'h0000, 16'h0000};
    drc_src_s    prio[5] = '{5'h08, 5'h01, 5'h02, 5'h04, 5'h10};

    // The clock toggles every half period of 50 ns.
    always #50 clock = ~clock;

    drc_top i_dut (.clock(clock), .rst_n(rst_n), .reg_bus(bus), .rdata(rdata),
        .dma_req(dma_req), .dma_ack(dma_ack), .bus_req(bus_req), .bus_ack(bus_ack));
    drc_far i_far (.want(want), .clock(clock), .rst_n(rst_n), .hold(hold), .slow(slow),
        .dma_ack(dma_ack), .bus_req(bus_req), .dma_req(dma_req), .bus_ack(bus_ack));

    // Grants are logged in the order in which they first appear.
    always @(posedge clock) begin
        if (dma_ack !== last && dma_ack !== '0) seen.push_back(dma_ack);
        last <= dma_ack;
    end
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Counts: %0d checks, %0d failures", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check_data(drc_data_t got, drc_data_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_src(drc_src_s got, drc_src_s exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(logic [31:0] a, drc_data_t d);
        @(posedge clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [31:0] a, drc_data_t exp);
        @(posedge clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        check_data(rdata, exp);
    endtask
    // Waits a bounded time for the grant lines to show a value, then compares.
    task automatic wait_ack(drc_src_s exp);
        int k;
        k = 0;
        while (dma_ack !== exp && k < 50) begin
            @(posedge clock);
            #1;
            k++;
        end
        check_src(dma_ack, exp);
        if (k == 50) finish_test();
    endtask
    ////////////////////////////////////////////////////////////
    // The main sequence resets the block and runs the tests in turn.
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) rd_reg(addrs[i], exp_rst[i]);
        for (i = 0; i < 6; i++) wr_reg(addrs[i], 16'h001f);
        for (i = 0; i < 6; i++) rd_reg(addrs[i], exp_set[i]);
        wr_reg(`DRC_ADDR_RESET, 16'h0000);
        $display("Test register map done");
        seen.delete();
        want <= 5'h1f;
        for (n = 0; n < 300 && seen.size() < 5; n++) @(posedge clock);
        check_data(16'(seen.size()), 16'h0005);
        for (i = 0; i < 5 && i < seen.size(); i++) check_src(seen[i], prio[i]);
        want <= '0;
        wait_ack('0);
        $display("Test priority order done");
        repeat (4) @(posedge clock);
        wr_reg(`DRC_ADDR_XFER_EN, 16'h0001);
        slow <= 1'b1;
        want <= 5'h11;
        wait_ack(5'h01);
        wait_ack('0);
        repeat (3) @(posedge clock);
        rd_reg(`DRC_ADDR_REQ, 16'h0010);
        rd_reg(`DRC_ADDR_IDLE, 16'h0001);
        check_data(16'(bus_req), 16'h0000);
        wr_reg(`DRC_ADDR_SEQ_EN, 16'h0000);
        wr_reg(`DRC_ADDR_XFER_EN, 16'h0010);
        repeat (5) @(posedge clock);
        check_data(16'(bus_req), 16'h0000);
        wr_reg(`DRC_ADDR_SEQ_EN, 16'h0001);
        wait_ack(5'h10);
        wait_ack('0);
        want <= '0;
        $display("Test enables done");
        repeat (4) @(posedge clock);
        wr_reg(`DRC_ADDR_XFER_EN, 16'h001f);
        hold <= 1'b1;
        slow <= 1'b0;
        want <= 5'h08;
        wait_ack(5'h08);
        rd_reg(`DRC_ADDR_IDLE, 16'h0000);
        wr_reg(`DRC_ADDR_RESET, 16'h0001);
        repeat (2) @(posedge clock);
        #1;
        check_src(dma_ack, '0);
        check_data(16'(bus_req), 16'h0000);
        repeat (3) @(posedge clock);
        rd_reg(`DRC_ADDR_IDLE, 16'h0001);
        rd_reg(`DRC_ADDR_RESET, 16'h0001);
        wr_reg(`DRC_ADDR_RESET, 16'h0000);
        wait_ack(5'h08);
        hold <= 1'b0;
        wait_ack('0);
        want <= '0;
        $display("Test controller reset done");
        finish_test();
    end
endmodule
